// file: c26_pkg.sv
// c26_pkg: constants, mode codes and opcode encodings for the 26-bit
// compatibility status update block.
// assumes a single core clock domain; users import c26_pkg::*.
package c26_pkg;
    localparam int C26_XLEN = 32;
    localparam int C26_MODE_W = 5;
    localparam int C26_NUM_SAVED = 5;
    localparam int C26_NUM_MODES = 10;
    localparam int C26_TOP_ZERO_BITS = 6;

    localparam logic [4:0] C26_MODE_USER_NARROW_MODE = 5'h00;
    localparam logic [4:0] C26_MODE_FAST_IRQ_NARROW_MODE = 5'h01;
    localparam logic [4:0] C26_MODE_IRQ_NARROW_MODE = 5'h02;
    localparam logic [4:0] C26_MODE_SUPERVISOR_NARROW_MODE = 5'h03;
    localparam logic [4:0] C26_MODE_USR32 = 5'h10;
    localparam logic [4:0] C26_MODE_FIQ32 = 5'h11;
    localparam logic [4:0] C26_MODE_IRQ32 = 5'h12;
    localparam logic [4:0] C26_MODE_SVC32 = 5'h13;
    localparam logic [4:0] C26_MODE_ABT32 = 5'h17;
    localparam logic [4:0] C26_MODE_UND32 = 5'h1B;

    localparam logic [3:0] C26_OP_AND = 4'h0;
    localparam logic [3:0] C26_OP_EOR = 4'h1;
    localparam logic [3:0] C26_OP_SUB = 4'h2;
    localparam logic [3:0] C26_OP_ADD = 4'h4;
    localparam logic [3:0] C26_OP_TST = 4'h8;
    localparam logic [3:0] C26_OP_TEQ = 4'h9;
    localparam logic [3:0] C26_OP_CMP = 4'hA;
    localparam logic [3:0] C26_OP_CMN = 4'hB;
    localparam logic [3:0] C26_OP_MOV = 4'hD;
    localparam logic [3:0] C26_REG_PC = 4'hF;

    localparam int C26_BIT_N = 31;
    localparam int C26_BIT_Z = 30;
    localparam int C26_BIT_C = 29;
    localparam int C26_BIT_V = 28;
    localparam int C26_BIT_I = 7;
    localparam int C26_BIT_F = 6;
    localparam int C26_RES_I = 27;
    localparam int C26_RES_F = 26;

    localparam logic [31:0] C26_STATUS_RESET = 32'h000000D3;
    localparam int C26_STATUS_CYCLES = 3;

    typedef enum logic [1:0] {C26_EXC_NONE, C26_EXC_FIQ, C26_EXC_IRQ, C26_EXC_SVC} c26_exc_unused_t;
endpackage : c26_pkg

// file: c26_alu.sv
// c26_alu: combinational data-processing result and flags.
// assumes operands are already shifted; only the opcodes below are served.
`timescale 1ns/1ps
module c26_alu (
    input wire logic [3:0] opcode,
    input wire logic [31:0] op_a,
    input wire logic [31:0] op_b,
    input wire logic carry_in,
    output logic [31:0] result,
    output logic carry_out,
    output logic overflow
);
    import c26_pkg::*;
    wire logic [32:0] sum_w = {1'b0, op_a} + {1'b0, op_b};
    wire logic [32:0] diff_w = {1'b0, op_a} + {1'b0, ~op_b} + 33'h000000001;
    wire logic is_add = (opcode == C26_OP_ADD) || (opcode == C26_OP_CMN);
    wire logic is_sub = (opcode == C26_OP_SUB) || (opcode == C26_OP_CMP);
    wire logic is_and = (opcode == C26_OP_AND) || (opcode == C26_OP_TST);
    wire logic is_eor = (opcode == C26_OP_EOR) || (opcode == C26_OP_TEQ);

    always_comb begin
        result = op_b;
        carry_out = carry_in;
        overflow = 1'b0;
        if (is_add) begin
            result = sum_w[31:0];
            carry_out = sum_w[32];
            overflow = (op_a[31] == op_b[31]) && (sum_w[31] != op_a[31]);
        end else if (is_sub) begin
            result = diff_w[31:0];
            carry_out = diff_w[32];
            overflow = (op_a[31] != op_b[31]) && (diff_w[31] != op_a[31]);
        end else if (is_and) begin
            result = op_a & op_b;
        end else if (is_eor) begin
            result = op_a ^ op_b;
        end
    end
endmodule : c26_alu

// file: c26_bank.sv
// c26_bank: one saved status word, loaded when its exception is taken.
// assumes capture strobes are one-cycle pulses.
`timescale 1ns/1ps
module c26_bank (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic capture,
    input wire logic [31:0] capture_value,
    output logic [31:0] saved_value
);
    import c26_pkg::*;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            saved_value <= C26_STATUS_RESET;
        end else if (capture) begin
            saved_value <= capture_value;
        end
    end
endmodule : c26_bank

// file: c26_status_update.sv
// c26_status_update: decode and status-word update for 26-bit compatible
// data processing, status-writing compares and load-multiple of the pc.
// assumes one instruction presented at a time with issue held until done;
// shifted operand and extra shift cycles come from the issuing stage.
//
// Notes on behaviour
// - compare forms with destination all ones become status-writing; normal flags suppressed.
// - status-writing compares compute sum, difference, exclusive or, and.
// - user mode copies result bits 31..28 into N Z C V only.
// - privileged modes copy bits 31..26 and bits 1..0 into flags, I, F, mode.
// - status-writing compares take three cycles plus extra shift cycles.
// - flag-setting data processing to the pc is legal in user mode.
// - pc writes with S set never copy the saved status word.
// - load-multiple with pc and S is legal in user mode, sets flags.
// - privileged load-multiple sets flags, I, F and low mode bits.
// - no address exception in 26-bit modes; aborts come from outside.
// - 26-bit cycle counts equal the 32-bit ones.
// - no width configuration pins; always full 32-bit program and data.
// - ten operating modes are recognised.
// - five saved status words, each captured on an exception into its 32-bit mode.
// - mode field is five bits wide, three more than the older format.
// - both widths share banks pairwise; abort and undefined have their own.
// - top six pc bits held at zero in any 26-bit mode, except in the cycle an exception vector is loaded.
// - mode codes 00000 to 00011 select the four 26-bit modes.
`timescale 1ns/1ps
module c26_status_update #(
    parameter int EXTRA_W = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic issue,
    input wire logic [31:0] instr,
    input wire logic [31:0] op_a,
    input wire logic [31:0] op_b,
    input wire logic shift_carry,
    input wire logic [EXTRA_W-1:0] extra_cycles,
    input wire logic [31:0] loaded_pc_word,
    input wire logic exc_take,
    input wire logic [c26_pkg::C26_MODE_W-1:0] exc_mode,
    input wire logic [31:0] exc_vector,
    input wire logic [31:0] next_seq_pc,
    output logic busy,
    output logic done,
    output logic illegal,
    output logic reg_write,
    output logic [3:0] reg_dest,
    output logic [31:0] reg_data,
    output logic [31:0] current_status_word,
    output logic [31:0] saved_status_word,
    output logic [31:0] pc,
    output logic narrow_mode,
    output logic [1:0] bank_sel,
    output logic address_exception
);
    import c26_pkg::*;

    // the cycle counter is five bits wide, so wider extra counts would wrap
    if (EXTRA_W < 1 || EXTRA_W > 4) begin : g_bad_extra
        $error("c26_status_update: EXTRA_W must be 1..4");
    end

    typedef enum logic [1:0] {C26_IDLE, C26_RUN, C26_FINISH} c26_state_t;
    c26_state_t state;
    c26_state_t next_state;
    logic [4:0] count;
    logic [4:0] next_count;
    logic [31:0] held_result;
    logic [3:0] held_dest;
    logic held_wr;
    logic held_status;
    logic held_setflags;
    logic held_c;
    logic held_v;
    logic held_is_ldm;

    // instruction field decode
    wire logic is_dp = (instr[27:26] == 2'b00) && !(instr[25] == 1'b0 && instr[7] && instr[4]);
    wire logic is_ldm = (instr[27:25] == 3'b100) && instr[20];
    wire logic [3:0] opc = instr[24:21];
    wire logic s_bit = instr[20];
    wire logic [3:0] rd = instr[15:12];
    wire logic is_cmp_class = opc[3:2] == 2'b10;
    wire logic dest_all_ones = rd == C26_REG_PC;
    wire logic cmp_status = is_dp && is_cmp_class && s_bit && dest_all_ones;
    wire logic dp_pc_s = is_dp && !is_cmp_class && s_bit && dest_all_ones;
    wire logic ldm_pc_s = is_ldm && instr[15] && instr[22];
    wire logic writes_status = cmp_status || dp_pc_s;

    // mode decode
    wire logic [4:0] mode = current_status_word[C26_MODE_W-1:0];
    wire logic mode_narrow = mode[4:2] == 3'b000;
    wire logic mode_user = (mode == C26_MODE_USER_NARROW_MODE) || (mode == C26_MODE_USR32);
    wire logic mode_known = mode_narrow
        || mode == C26_MODE_USR32 || mode == C26_MODE_FIQ32
        || mode == C26_MODE_IRQ32 || mode == C26_MODE_SVC32
        || mode == C26_MODE_ABT32 || mode == C26_MODE_UND32;

    wire logic [31:0] alu_result;
    wire logic alu_c;
    wire logic alu_v;
    c26_alu u_alu (
        .opcode(opc),
        .op_a(op_a),
        .op_b(op_b),
        .carry_in(shift_carry),
        .result(alu_result),
        .carry_out(alu_c),
        .overflow(alu_v)
    );

    // saved status words, one per exception mode
    wire logic [31:0] saved_all [C26_NUM_SAVED];
    wire logic [4:0] exc_idx;
    assign exc_idx = exc_mode[4:0];
    genvar g;
    generate
        for (g = 0; g < C26_NUM_SAVED; g++) begin : g_saved
            wire logic [4:0] owner_mode = (g == 0) ? C26_MODE_FIQ32 :
                (g == 1) ? C26_MODE_IRQ32 : (g == 2) ? C26_MODE_SVC32 :
                (g == 3) ? C26_MODE_ABT32 : C26_MODE_UND32;
            c26_bank u_bank (
                .core_clk(core_clk),
                .rst(rst),
                .capture(exc_take && exc_idx == owner_mode),
                .capture_value(current_status_word),
                .saved_value(saved_all[g])
            );
        end
    endgenerate

    // low two mode bits pick the bank for both widths; abort and undefined are picked by the full mode
    wire logic [2:0] saved_idx = (mode[1:0] == 2'b01) ? 3'h0 :
        (mode[1:0] == 2'b10) ? 3'h1 :
        (mode == C26_MODE_ABT32) ? 3'h3 :
        (mode == C26_MODE_UND32) ? 3'h4 : 3'h2;
    wire logic [1:0] next_bank = (mode == C26_MODE_ABT32) ? 2'h2 :
        (mode == C26_MODE_UND32) ? 2'h3 :
        (mode[1:0] == 2'b01) ? 2'h1 : 2'h0;

    // status word image from a source value; the saved word is never used here
    function automatic logic [31:0] c26_apply(input logic [31:0] cur, input logic [31:0] src,
                                             input logic user);
        logic [31:0] res;
        res = cur;
        res[C26_BIT_N:C26_BIT_V] = src[31:28];
        if (!user) begin
            res[C26_BIT_I] = src[C26_RES_I];
            res[C26_BIT_F] = src[C26_RES_F];
            res[1:0] = src[1:0];
        end
        return res;
    endfunction : c26_apply

    wire logic [31:0] dp_status = c26_apply(current_status_word, held_result, mode_user);
    wire logic [31:0] ldm_status = c26_apply(current_status_word, loaded_pc_word, mode_user);
    wire logic [31:0] flag_status = {held_result[31], held_result == 32'h00000000,
                                     held_c, held_v, current_status_word[27:0]};

    // cycle budget; same for both widths since mode does not enter it
    wire logic [4:0] base_count = cmp_status ? 5'(C26_STATUS_CYCLES) : 5'h01;
    wire logic [4:0] issue_count = base_count + 5'(extra_cycles);

    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            C26_IDLE: begin
                if (issue && (is_dp || ldm_pc_s)) begin
                    next_state = (issue_count > 5'h01) ? C26_RUN : C26_FINISH;
                    next_count = issue_count - 5'h01;
                end
            end
            C26_RUN: begin
                next_count = count - 5'h01;
                if (count == 5'h01) begin
                    next_state = C26_FINISH;
                end
            end
            C26_FINISH: begin
                next_state = C26_IDLE;
                next_count = 5'h00;
            end
            default: begin
                next_state = C26_IDLE;
                next_count = 5'h00;
            end
        endcase
    end

    wire logic start = state == C26_IDLE && issue && (is_dp || ldm_pc_s);
    // done rises on the same edge as the status and pc load of the finish cycle
    wire logic finish = state == C26_FINISH;
    // narrow modes clamp the top six bits on every pc update except the exception vector load
    wire logic [31:0] pc_mask = mode_narrow ? 32'h03FFFFFF : 32'hFFFFFFFF;
    wire logic [31:0] pc_target = held_is_ldm ? loaded_pc_word : held_result;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= C26_IDLE;
            count <= 5'h00;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            held_result <= 32'h00000000;
            held_dest <= 4'h0;
            held_wr <= 1'b0;
            held_status <= 1'b0;
            held_setflags <= 1'b0;
            held_c <= 1'b0;
            held_v <= 1'b0;
            held_is_ldm <= 1'b0;
        end else if (start) begin
            held_result <= alu_result;
            held_dest <= rd;
            held_wr <= !is_cmp_class && !ldm_pc_s;
            held_status <= writes_status || ldm_pc_s;
            held_setflags <= s_bit && !dest_all_ones && !ldm_pc_s;
            held_c <= alu_c;
            held_v <= alu_v;
            held_is_ldm <= ldm_pc_s;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            current_status_word <= C26_STATUS_RESET;
            pc <= 32'h00000000;
        end else if (exc_take) begin
            // exceptions land in whatever mode exc_mode gives, 26-bit or 32-bit
            current_status_word <= {current_status_word[31:5], exc_mode};
            pc <= exc_vector;
        end else if (state == C26_FINISH) begin
            if (held_status) begin
                current_status_word <= held_is_ldm ? ldm_status : dp_status;
            end else if (held_setflags) begin
                current_status_word <= flag_status;
            end
            if (held_status && !(held_wr == 1'b0 && !held_is_ldm)) begin
                pc <= pc_target & pc_mask;
            end else if (held_wr && held_dest == C26_REG_PC) begin
                pc <= held_result & pc_mask;
            end else begin
                pc <= next_seq_pc & pc_mask;
            end
        end else begin
            pc <= pc & pc_mask;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy <= 1'b0;
            done <= 1'b0;
            illegal <= 1'b0;
            reg_write <= 1'b0;
            reg_dest <= 4'h0;
            reg_data <= 32'h00000000;
            saved_status_word <= C26_STATUS_RESET;
            narrow_mode <= 1'b1;
            bank_sel <= 2'h0;
            address_exception <= 1'b0;
        end else begin
            busy <= next_state != C26_IDLE;
            done <= finish;
            illegal <= issue && state == C26_IDLE && !mode_known;
            reg_write <= state == C26_FINISH && held_wr && held_dest != C26_REG_PC;
            reg_dest <= held_dest;
            reg_data <= held_result;
            saved_status_word <= saved_all[saved_idx];
            // narrow_mode stays low in the exception cycle, whose vector load into the pc is not clamped
            narrow_mode <= mode_narrow && !exc_take;
            bank_sel <= next_bank;
            address_exception <= 1'b0;
        end
    end
endmodule : c26_status_update

// file: c26_status_update_assertions.sv
// c26_status_update_assertions: port-level checks for c26_status_update.
// assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module c26_status_update_assertions #(
    parameter int EXTRA_W = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic issue,
    input wire logic [31:0] instr,
    input wire logic [EXTRA_W-1:0] extra_cycles,
    input wire logic exc_take,
    input wire logic [4:0] exc_mode,
    input wire logic busy,
    input wire logic done,
    input wire logic illegal,
    input wire logic reg_write,
    input wire logic [31:0] current_status_word,
    input wire logic [31:0] saved_status_word,
    input wire logic [31:0] pc,
    input wire logic narrow_mode,
    input wire logic address_exception
);
    import c26_pkg::*;
    wire logic is_dp = instr[27:26] == 2'b00 && instr[25] == 1'b0 && instr[20]
        && !(instr[7] && instr[4]);
    wire logic stat_cmp = is_dp && instr[24:23] == 2'b10 && instr[15:12] == 4'hF;
    wire logic take = issue && !busy;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_no_addr_exc: assert property (!address_exception)
        else $error("address exception raised");
    chk_cmp_three_cycles: assert property (
        take && stat_cmp && extra_cycles == 0 |=> !done [*3] ##1 done)
        else $error("status compare latency wrong");
    chk_dp_one_cycle: assert property (
        take && is_dp && !stat_cmp && extra_cycles == 0 |=> !done ##1 done)
        else $error("data processing latency wrong");
    chk_cmp_no_regwr: assert property (take && stat_cmp |=> !reg_write [*4])
        else $error("status compare wrote a register");
    chk_user_flags_only: assert property (
        done && !$past(exc_take) && $past(current_status_word[3:0]) == 4'h0
        |-> current_status_word[27:0] == $past(current_status_word[27:0]))
        else $error("user mode changed more than the flags");
    chk_user_legal: assert property (
        take && current_status_word[4:0] == C26_MODE_USR32 |=> !illegal)
        else $error("user mode pc write refused");
    chk_exc_save: assert property (
        exc_take && exc_mode[4] && exc_mode[3:0] != 4'h0
        |=> ##1 saved_status_word == $past(current_status_word, 2))
        else $error("saved status word not captured");
    chk_exc_mode: assert property (
        exc_take |=> current_status_word[4:0] == $past(exc_mode))
        else $error("exception mode not entered");
    chk_narrow_pc_top: assert property (narrow_mode |-> pc[31:26] == 6'h00)
        else $error("pc top bits set in narrow mode");
    cov_cmp: cover property (take && stat_cmp);
    cov_ldm: cover property (take && instr[27:25] == 3'b100 && instr[15]);
    cov_exc: cover property (exc_take);
    cov_narrow: cover property (narrow_mode);
endmodule : c26_status_update_assertions

bind c26_status_update c26_status_update_assertions #(.EXTRA_W(EXTRA_W)) c26_status_update_assertions_i (
    .core_clk(core_clk), .rst(rst), .issue(issue), .instr(instr),
    .extra_cycles(extra_cycles), .exc_take(exc_take), .exc_mode(exc_mode),
    .busy(busy), .done(done), .illegal(illegal), .reg_write(reg_write),
    .current_status_word(current_status_word), .saved_status_word(saved_status_word),
    .pc(pc), .narrow_mode(narrow_mode), .address_exception(address_exception));

// file: c26_status_update_test.sv
// c26_status_update_test: table-driven bench for c26_status_update.
// assumes the package and design files are compiled first.
`timescale 1ns/1ps
module c26_status_update_test;
    import c26_pkg::*;
    typedef struct {logic [31:0] ins, a, b, ld; logic [1:0] ex; logic [31:0] cs; int n;} c26_row_t;
    logic core_clk = 0, rst = 1, issue = 0, shift_carry = 0, exc_take = 0;
    logic [31:0] instr = 0, op_a = 0, op_b = 0, loaded_pc_word = 0;
    logic [31:0] exc_vector = 0, next_seq_pc = 32'h00000040;
    logic [1:0] extra_cycles = 0;
    logic [4:0] exc_mode = C26_MODE_SVC32;
    logic busy, done, illegal, reg_write, narrow_mode, address_exception;
    logic [3:0] reg_dest;
    logic [1:0] bank_sel;
    logic [31:0] reg_data, current_status_word, saved_status_word, pc;
    int miscompares = 0, n_checks = 0, cycles = 0, n;
    logic rw, il;
    // rows run in order: each but row 6, which follows an exception into SVC32, starts from the status left by the previous one
    c26_row_t rows[8] = '{
        '{32'hE110F000, 32'hF0000003, 32'hFFFFFFFF, 32'h0, 2'h0, 32'hF0000013, 3},
        '{32'hE130F000, 32'h0C000000, 32'h00000000, 32'h0, 2'h0, 32'h000000D0, 3},
        '{32'hE150F000, 32'h00000005, 32'h00000006, 32'h0, 2'h2, 32'hF00000D0, 5},
        '{32'hE170F000, 32'h20000000, 32'h40000000, 32'h0, 2'h0, 32'h600000D0, 3},
        '{32'hE090F000, 32'h80000000, 32'h00000003, 32'h0, 2'h1, 32'h800000D0, 2},
        '{32'hE8D08001, 32'h0, 32'h0, 32'hA0000003, 2'h0, 32'hA00000D0, 1},
        '{32'hE8D08001, 32'h0, 32'h0, 32'h0C000002, 2'h0, 32'h000000D2, 1},
        '{32'hE010F000, 32'hFFFFFFFF, 32'h30000001, 32'h0, 2'h0, 32'h30000011, 1}};

    c26_status_update #(.EXTRA_W(2)) c26_status_update_i (
        .core_clk(core_clk), .rst(rst), .issue(issue), .instr(instr), .op_a(op_a),
        .op_b(op_b), .shift_carry(shift_carry), .extra_cycles(extra_cycles),
        .loaded_pc_word(loaded_pc_word), .exc_take(exc_take), .exc_mode(exc_mode),
        .exc_vector(exc_vector), .next_seq_pc(next_seq_pc), .busy(busy), .done(done),
        .illegal(illegal), .reg_write(reg_write), .reg_dest(reg_dest),
        .reg_data(reg_data), .current_status_word(current_status_word),
        .saved_status_word(saved_status_word), .pc(pc), .narrow_mode(narrow_mode),
        .bank_sel(bank_sel), .address_exception(address_exception));

    always #5 core_clk = ~core_clk;

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask : check

    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // n counts edges after the last issue edge until done is seen
    task run(input c26_row_t r, input int hold);
        @(posedge core_clk);
        issue <= 1'b1;
        instr <= r.ins;
        op_a <= r.a;
        op_b <= r.b;
        loaded_pc_word <= r.ld;
        extra_cycles <= r.ex;
        repeat (hold + 1) @(posedge core_clk);
        issue <= 1'b0;
        #1;
        il = illegal;
        n = 0;
        rw = 1'b0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
            rw |= reg_write;
        end while (done !== 1'b1 && n < 20);
    endtask : run

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        check("reset status", C26_STATUS_RESET, current_status_word);
        check("reset pc", 32'h0, pc);
        for (int i = 0; i < 8; i++) begin
            if (i == 6) begin
                @(posedge core_clk);
                exc_take <= 1'b1;
                exc_vector <= 32'h00000100;
                @(posedge core_clk);
                exc_take <= 1'b0;
                @(posedge core_clk);
                #1;
                check("saved word", 32'hA00000D0, saved_status_word);
                check("exc mode", {27'h0, C26_MODE_SVC32}, {27'h0, current_status_word[4:0]});
                check("exc pc", 32'h00000100, pc);
            end
            run(rows[i], 0);
            check("status", rows[i].cs, current_status_word);
            check("cycles", rows[i].n, n);
            if (i < 4) check("reg write", 32'h0, {31'h0, rw});
            check("illegal", 32'h0, {31'h0, il});
            check("addr exc", 32'h0, {31'h0, address_exception});
        end
        @(posedge core_clk);
        #1;
        check("bank", 32'h1, {30'h0, bank_sel});
        // a second issue while busy must be ignored
        run('{32'hE150F000, 32'h0, 32'h1, 32'h0, 2'h0, 32'h0, 0}, 1);
        check("busy issue", 32'hF00000D3, current_status_word);
        n = 0;
        repeat (6) begin
            @(posedge core_clk);
            #1;
            if (done === 1'b1) n++;
        end
        check("extra done", 32'h0, n);
        // enter a narrow mode from a high vector; the pc must be clamped
        @(posedge core_clk);
        exc_take <= 1'b1;
        exc_mode <= C26_MODE_SUPERVISOR_NARROW_MODE;
        exc_vector <= 32'hFC000100;
        @(posedge core_clk);
        exc_take <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check("narrow flag", 32'h1, {31'h0, narrow_mode});
        check("narrow pc", 32'h00000100, pc);
        // reset in mid-instruction
        run('{32'hE150F000, 32'h0, 32'h1, 32'h0, 2'h3, 32'h0, 0}, 0);
        @(posedge core_clk);
        issue <= 1'b1;
        @(posedge core_clk);
        issue <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        check("rerst status", C26_STATUS_RESET, current_status_word);
        check("rerst busy", 32'h0, {31'h0, busy});
        tally_and_finish();
    end
endmodule : c26_status_update_test
